/* File: riex_consts.vh */
// Constants for the reset and interrupt exception unit
`ifndef RIEX_CONSTS_VH
`define RIEX_CONSTS_VH

// Register indexes; byte address is four times the index
`define RIEX_IDX_WAKE_EDGE   16'hFF90
`define RIEX_IDX_EXT_EDGE    16'hFFF2
`define RIEX_IDX_EN1         16'hFFF3
`define RIEX_IDX_EN2         16'hFFF4
`define RIEX_IDX_REQ1        16'hFFF6
`define RIEX_IDX_REQ2        16'hFFF7
`define RIEX_IDX_WAKE_REQ    16'hFFF9
`define RIEX_IDX_MASK        16'hFFFA
`define RIEX_IDX_STAT        16'hFFFB
`define RIEX_IDX_AUX_EDGE    16'hFFFC

// Implemented bits, forced ones and reset values
`define RIEX_EXT_EDGE_RW     8'h03
`define RIEX_EXT_EDGE_ONES   8'hE0
`define RIEX_EN1_RW          8'hA7
`define RIEX_EN2_RW          8'hCD
`define RIEX_REQ1_FLAGS      8'h87
`define RIEX_REQ1_ONES       8'h20
`define RIEX_REQ2_FLAGS      8'hCD
`define RIEX_REG_RESET       8'h00
`define RIEX_MASK_RESET      1'b1
`define RIEX_EXT_EDGE_RESET  2'b00
`define RIEX_AUX_EDGE_RESET  1'b0
`define RIEX_PIN_IDLE        11'h7FF

// Bit positions in the enable and request registers
`define RIEX_B1_TA           7
`define RIEX_B1_WP           5
`define RIEX_B1_AEC          2
`define RIEX_B1_EXT_INT_PIN_1         1
`define RIEX_B1_EXT_INT_PIN_0         0
`define RIEX_B2_DT           7
`define RIEX_B2_AD           6
`define RIEX_B2_FH           3
`define RIEX_B2_FL           2
`define RIEX_B2_EC           0

// Vector numbers
`define RIEX_VEC_RESET       5'h00
`define RIEX_VEC_EXT_INT_PIN_0        5'h04
`define RIEX_VEC_EXT_INT_PIN_1        5'h05
`define RIEX_VEC_AEC         5'h06
`define RIEX_VEC_WAKE        5'h09
`define RIEX_VEC_TA          5'h0B
`define RIEX_VEC_EC          5'h0C
`define RIEX_VEC_FL          5'h0E
`define RIEX_VEC_FH          5'h0F
`define RIEX_VEC_SERIAL      5'h12
`define RIEX_VEC_AD          5'h13
`define RIEX_VEC_DT          5'h14

// Edge pin slots in the combined pin bus
`define RIEX_PIN_AEC         10
`define RIEX_PIN_EXT_INT_PIN_1        9
`define RIEX_PIN_EXT_INT_PIN_0        8

`endif

/* File: riex_ctrl.v */
// Reset sequencing, interrupt flags, priority and vector selection with AHB-Lite registers
`timescale 1ns/1ns
`include "riex_consts.vh"

module riex_ctrl (
  // Clock, reset, enable
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // External interrupt and wakeup pins
  input  wire [1:0]  ext_int_pin,
  input  wire        event_counter_int_pin,
  input  wire [7:0]  wakeup_pins,
  // Peripheral request lines
  input  wire        timer_a_ovf,
  input  wire        aec_ovf,
  input  wire        timer_low_cmp,
  input  wire        timer_low_ovf,
  input  wire        timer_high_cmp,
  input  wire        timer_high_ovf,
  input  wire [5:0]  serial_irq,
  input  wire        adc_done,
  input  wire        sleep_direct,
  // CPU core side
  input  wire        instr_done,
  output wire        cpu_hold,
  output wire        exc_take,
  output wire [4:0]  exc_vector,
  output wire [15:0] exc_vec_addr,
  output wire        int_mask
);

  localparam [1:0] ST_RESET = 2'b00;
  localparam [1:0] ST_RUN   = 2'b01;

  reg  [1:0]  state_q;
  reg         cpu_hold_q;
  reg         first_done_q;
  reg         i_mask_q;
  reg         exc_take_q;
  reg  [4:0]  exc_vector_q;
  reg  [15:0] exc_vec_addr_q;

  reg  [7:0]  wake_edge_q;
  reg  [1:0]  ext_edge_q;
  reg         aux_edge_q;
  reg  [7:0]  en1_q;
  reg  [7:0]  en2_q;
  reg  [7:0]  req1_q;
  reg  [7:0]  req2_q;
  reg  [7:0]  wake_req_q;
  reg  [10:0] pin_prev_q;

  reg         wr_phase_q;
  reg  [15:0] wr_idx_q;
  reg  [31:0] hrdata_q;

  // Bus decode
  wire        addr_phase;
  wire        addr_mapped;
  wire [15:0] addr_idx;
  wire        wr_fire;
  wire [7:0]  wbyte;

  assign addr_phase  = hsel & hready & htrans[1];
  assign addr_mapped = (haddr[31:18] == 14'h0000) & (haddr[1:0] == 2'b00);
  assign addr_idx    = haddr[17:2];
  assign wr_fire     = wr_phase_q & ce;
  assign wbyte       = hwdata[7:0];

  // Zero-wait slave; a low clock enable stretches the transfer
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Edge detection for eleven pins
  wire [10:0] pins_w;
  wire [10:0] sel_w;
  wire [10:0] edge_w;

  assign pins_w = {event_counter_int_pin, ext_int_pin, wakeup_pins};
  assign sel_w  = {aux_edge_q, ext_edge_q, wake_edge_q};

  genvar gi;
  generate
    for (gi = 0; gi < 11; gi = gi + 1) begin : g_edge
      // 0 falling, 1 rising
      assign edge_w[gi] = sel_w[gi] ? (pins_w[gi] & ~pin_prev_q[gi])
                                    : (~pins_w[gi] & pin_prev_q[gi]);
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev_q <= `RIEX_PIN_IDLE;
    end else if (ce) begin
      pin_prev_q <= pins_w;
    end
  end

  // Flag set and clear terms
  wire [7:0] req1_set;
  wire [7:0] req2_set;
  wire [7:0] req1_clr;
  wire [7:0] req2_clr;
  wire [7:0] wake_clr;

  assign req1_set = {timer_a_ovf, 4'h0, edge_w[`RIEX_PIN_AEC],
                     edge_w[`RIEX_PIN_EXT_INT_PIN_1], edge_w[`RIEX_PIN_EXT_INT_PIN_0]};
  assign req2_set = {sleep_direct, adc_done, 2'b00,
                     timer_high_cmp | timer_high_ovf,
                     timer_low_cmp | timer_low_ovf, 1'b0, aec_ovf};

  // Only zero bits clear; ones written are ignored
  assign req1_clr = (wr_fire && wr_idx_q == `RIEX_IDX_REQ1) ?
                    (~wbyte & `RIEX_REQ1_FLAGS) : 8'h00;
  assign req2_clr = (wr_fire && wr_idx_q == `RIEX_IDX_REQ2) ?
                    (~wbyte & `RIEX_REQ2_FLAGS) : 8'h00;
  assign wake_clr = (wr_fire && wr_idx_q == `RIEX_IDX_WAKE_REQ) ?
                    ~wbyte : 8'h00;

  // Flags are set regardless of mask; a set in the clearing cycle wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req1_q <= `RIEX_REG_RESET;
    end else if (ce) begin
      req1_q <= ((req1_q & ~req1_clr) | req1_set) & `RIEX_REQ1_FLAGS;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req2_q <= `RIEX_REG_RESET;
    end else if (ce) begin
      req2_q <= ((req2_q & ~req2_clr) | req2_set) & `RIEX_REQ2_FLAGS;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_req_q <= `RIEX_REG_RESET;
    end else if (ce) begin
      wake_req_q <= (wake_req_q & ~wake_clr) | edge_w[7:0];
    end
  end

  // Software-written configuration
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_edge_q <= `RIEX_REG_RESET;
      ext_edge_q  <= `RIEX_EXT_EDGE_RESET;
      aux_edge_q  <= `RIEX_AUX_EDGE_RESET;
      en1_q       <= `RIEX_REG_RESET;
      en2_q       <= `RIEX_REG_RESET;
    end else if (wr_fire) begin
      if (wr_idx_q == `RIEX_IDX_WAKE_EDGE) begin
        wake_edge_q <= wbyte;
      end else if (wr_idx_q == `RIEX_IDX_EXT_EDGE) begin
        // Upper bits hold no storage
        ext_edge_q <= wbyte[1:0];
      end else if (wr_idx_q == `RIEX_IDX_AUX_EDGE) begin
        aux_edge_q <= wbyte[0];
      end else if (wr_idx_q == `RIEX_IDX_EN1) begin
        en1_q <= wbyte & `RIEX_EN1_RW;
      end else if (wr_idx_q == `RIEX_IDX_EN2) begin
        en2_q <= wbyte & `RIEX_EN2_RW;
      end
    end
  end

  // Pending sources, each gated only by its enable, except the ungated serial line
  wire p_ext_int_pin_0;
  wire p_ext_int_pin_1;
  wire p_aec;
  wire p_wake;
  wire p_ta;
  wire p_ec;
  wire p_fl;
  wire p_fh;
  wire p_ser;
  wire p_ad;
  wire p_dt;
  wire any_pend;

  assign p_ext_int_pin_0 = req1_q[`RIEX_B1_EXT_INT_PIN_0] & en1_q[`RIEX_B1_EXT_INT_PIN_0];
  assign p_ext_int_pin_1 = req1_q[`RIEX_B1_EXT_INT_PIN_1] & en1_q[`RIEX_B1_EXT_INT_PIN_1];
  assign p_aec  = req1_q[`RIEX_B1_AEC]  & en1_q[`RIEX_B1_AEC];
  assign p_wake = (|wake_req_q) & en1_q[`RIEX_B1_WP];
  assign p_ta   = req1_q[`RIEX_B1_TA]   & en1_q[`RIEX_B1_TA];
  assign p_ec   = req2_q[`RIEX_B2_EC]   & en2_q[`RIEX_B2_EC];
  assign p_fl   = req2_q[`RIEX_B2_FL]   & en2_q[`RIEX_B2_FL];
  assign p_fh   = req2_q[`RIEX_B2_FH]   & en2_q[`RIEX_B2_FH];
  // Serial events are already enabled inside the serial port
  assign p_ser  = |serial_irq;
  assign p_ad   = req2_q[`RIEX_B2_AD]   & en2_q[`RIEX_B2_AD];
  assign p_dt   = req2_q[`RIEX_B2_DT]   & en2_q[`RIEX_B2_DT];

  assign any_pend = p_ext_int_pin_0 | p_ext_int_pin_1 | p_aec | p_wake | p_ta | p_ec |
                    p_fl | p_fh | p_ser | p_ad | p_dt;

  // Fixed priority, lowest vector number first; reserved numbers never appear
  reg [4:0] win_vec;

  always @* begin
    win_vec = `RIEX_VEC_DT;
    if (p_ext_int_pin_0) begin
      win_vec = `RIEX_VEC_EXT_INT_PIN_0;
    end else if (p_ext_int_pin_1) begin
      win_vec = `RIEX_VEC_EXT_INT_PIN_1;
    end else if (p_aec) begin
      win_vec = `RIEX_VEC_AEC;
    end else if (p_wake) begin
      win_vec = `RIEX_VEC_WAKE;
    end else if (p_ta) begin
      win_vec = `RIEX_VEC_TA;
    end else if (p_ec) begin
      win_vec = `RIEX_VEC_EC;
    end else if (p_fl) begin
      win_vec = `RIEX_VEC_FL;
    end else if (p_fh) begin
      win_vec = `RIEX_VEC_FH;
    end else if (p_ser) begin
      win_vec = `RIEX_VEC_SERIAL;
    end else if (p_ad) begin
      win_vec = `RIEX_VEC_AD;
    end else begin
      win_vec = `RIEX_VEC_DT;
    end
  end

  // Acceptance only at a boundary, unmasked, and after the first instruction
  wire take_now;

  assign take_now = (state_q == ST_RUN) & instr_done & first_done_q &
                    ~i_mask_q & any_pend;

  wire mask_wr;

  assign mask_wr = wr_fire && (wr_idx_q == `RIEX_IDX_MASK);

  // Exception sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q        <= ST_RESET;
      cpu_hold_q     <= 1'b1;
      first_done_q   <= 1'b0;
      i_mask_q       <= `RIEX_MASK_RESET;
      exc_take_q     <= 1'b0;
      exc_vector_q   <= `RIEX_VEC_RESET;
      exc_vec_addr_q <= {10'h000, `RIEX_VEC_RESET, 1'b0};
    end else if (ce) begin
      exc_take_q <= 1'b0;
      case (state_q)
        ST_RESET: begin
          // Reset vector fetch on the first enabled edge after release
          exc_take_q     <= 1'b1;
          exc_vector_q   <= `RIEX_VEC_RESET;
          exc_vec_addr_q <= {10'h000, `RIEX_VEC_RESET, 1'b0};
          cpu_hold_q     <= 1'b0;
          state_q        <= ST_RUN;
        end
        ST_RUN: begin
          // Stack pointer setup must run before any interrupt
          if (instr_done) begin
            first_done_q <= 1'b1;
          end
          if (take_now) begin
            exc_take_q     <= 1'b1;
            exc_vector_q   <= win_vec;
            exc_vec_addr_q <= {10'h000, win_vec, 1'b0};
          end
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
      // Hardware setting of the mask wins over a software clear
      if (take_now) begin
        i_mask_q <= 1'b1;
      end else if (mask_wr) begin
        i_mask_q <= wbyte[0];
      end
    end
  end

  assign cpu_hold     = cpu_hold_q;
  assign exc_take     = exc_take_q;
  assign exc_vector   = exc_vector_q;
  assign exc_vec_addr = exc_vec_addr_q;
  assign int_mask     = i_mask_q;

  // Register read mux, sampled in the address phase
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    if (!addr_mapped) begin
      rd_byte = 8'h00;
    end else if (addr_idx == `RIEX_IDX_WAKE_EDGE) begin
      rd_byte = wake_edge_q;
    end else if (addr_idx == `RIEX_IDX_EXT_EDGE) begin
      rd_byte = `RIEX_EXT_EDGE_ONES | {6'h00, ext_edge_q};
    end else if (addr_idx == `RIEX_IDX_EN1) begin
      rd_byte = en1_q;
    end else if (addr_idx == `RIEX_IDX_EN2) begin
      rd_byte = en2_q;
    end else if (addr_idx == `RIEX_IDX_REQ1) begin
      rd_byte = req1_q | `RIEX_REQ1_ONES;
    end else if (addr_idx == `RIEX_IDX_REQ2) begin
      rd_byte = req2_q;
    end else if (addr_idx == `RIEX_IDX_WAKE_REQ) begin
      rd_byte = wake_req_q;
    end else if (addr_idx == `RIEX_IDX_MASK) begin
      rd_byte = {7'h00, i_mask_q};
    end else if (addr_idx == `RIEX_IDX_STAT) begin
      rd_byte = {any_pend, 2'b00, win_vec};
    end else if (addr_idx == `RIEX_IDX_AUX_EDGE) begin
      rd_byte = {7'h00, aux_edge_q};
    end
  end

  // Bus phase tracking; unmapped writes are dropped, answer is still OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_phase_q <= 1'b0;
      wr_idx_q   <= 16'h0000;
      hrdata_q   <= 32'h00000000;
    end else if (ce) begin
      wr_phase_q <= addr_phase & hwrite & addr_mapped;
      if (addr_phase) begin
        wr_idx_q <= addr_idx;
        if (!hwrite) begin
          hrdata_q <= {24'h000000, rd_byte};
        end
      end
    end
  end

endmodule // riex_ctrl

/* File: riex_checker.sv */
// Port assertions for the reset and interrupt exception unit
`timescale 1ns/1ns
module riex_checker (
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  input wire        ce,
  // CPU side
  input wire        instr_done,
  input wire        cpu_hold,
  input wire        exc_take,
  input wire [4:0]  exc_vector,
  input wire [15:0] exc_vec_addr,
  input wire        int_mask
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  reset_state_a: assert property ($rose(hresetn) |-> cpu_hold && int_mask)
    else $error("reset state not held up to release");
  reset_fetch_a: assert property ($rose(hresetn) && ce |=>
    exc_take && !cpu_hold && exc_vector == 5'h00)
    else $error("reset vector fetch missing after release");
  // A frozen clock enable legally stretches the take pulse
  take_pulse_a: assert property (exc_take && ce |=> !exc_take)
    else $error("vector take longer than one cycle");
  take_masks_a: assert property (exc_take |-> int_mask)
    else $error("mask bit clear during a take");
  mask_gate_a: assert property ($rose(exc_take) && exc_vector != 5'h00 |->
    $past(instr_done) && !$past(int_mask))
    else $error("take without boundary or while masked");
  vec_addr_a: assert property (exc_take |->
    exc_vec_addr == {10'h000, exc_vector, 1'b0})
    else $error("vector word address not twice the vector");
  legal_vec_a: assert property (exc_take |-> exc_vector inside {
    5'h00, 5'h04, 5'h05, 5'h06, 5'h09, 5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h14})
    else $error("reserved vector produced");
  vec_hold_a: assert property (!exc_take |-> $stable(exc_vector))
    else $error("vector changed without a take");
  run_hold_a: assert property (!cpu_hold |=> !cpu_hold)
    else $error("core held again without reset");
endmodule // riex_checker

bind riex_ctrl riex_checker u_riex_checker (
  .hclk         (hclk),
  .hresetn      (hresetn),
  .ce           (ce),
  .instr_done   (instr_done),
  .cpu_hold     (cpu_hold),
  .exc_take     (exc_take),
  .exc_vector   (exc_vector),
  .exc_vec_addr (exc_vec_addr),
  .int_mask     (int_mask)
);

/* File: riex_cpu_model.sv */
// CPU core model giving instruction boundaries to the exception unit
`timescale 1ns/1ns
module riex_cpu_model (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Boundary pacing
  input  wire [3:0] gap,
  output reg        instr_done
);
  reg [3:0] cnt_q;

  // A long gap models a slow multi-cycle instruction
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q      <= 4'h0;
      instr_done <= 1'b0;
    end else begin
      instr_done <= (cnt_q >= gap);
      cnt_q      <= (cnt_q >= gap) ? 4'h0 : cnt_q + 4'h1;
    end
  end
endmodule // riex_cpu_model

/* File: tb_top.sv */
// Self-checking testbench for the reset and interrupt exception unit
`timescale 1ns/1ns
`include "riex_consts.vh"
module tb_top;
  localparam [31:0] A_EDGE = `RIEX_IDX_EXT_EDGE * 4;
  localparam [31:0] A_EN1  = `RIEX_IDX_EN1 * 4;
  localparam [31:0] A_EN2  = `RIEX_IDX_EN2 * 4;
  localparam [31:0] A_REQ1 = `RIEX_IDX_REQ1 * 4;
  localparam [31:0] A_REQ2 = `RIEX_IDX_REQ2 * 4;
  localparam [31:0] A_MASK = `RIEX_IDX_MASK * 4;
  localparam [31:0] A_WREQ = `RIEX_IDX_WAKE_REQ * 4;
  localparam [31:0] A_STAT = `RIEX_IDX_STAT * 4;
  localparam [31:0] A_AUX  = `RIEX_IDX_AUX_EDGE * 4;
  localparam [31:0] A_WEDG = `RIEX_IDX_WAKE_EDGE * 4;

  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         ce = 1'b1;
  reg         hsel = 1'b0;
  reg         hwrite = 1'b0;
  reg  [1:0]  htrans = 2'h0;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] haddr = 32'h0;
  reg  [31:0] hwdata = 32'h0;
  reg  [1:0]  ext_int_pin = 2'h3;
  reg         event_counter_int_pin = 1'b1;
  reg  [7:0]  wakeup_pins = 8'hFF;
  reg  [7:0]  pls = 8'h00;
  reg  [5:0]  serial_irq = 6'h00;
  reg  [3:0]  gap = 4'h0;
  reg  [7:0]  v = 8'h00;
  wire        hreadyout, hresp, instr_done, cpu_hold, exc_take, int_mask;
  wire        timer_a_ovf, aec_ovf, timer_low_cmp, timer_low_ovf;
  wire        timer_high_cmp, timer_high_ovf, adc_done, sleep_direct;
  wire [31:0] hrdata;
  wire [4:0]  exc_vector;
  wire [15:0] exc_vec_addr;
  wire        hready = hreadyout;
  integer     n_fail = 0;
  integer     n_tests = 0;
  integer     cyc = 0;
  integer     takes = 0;
  integer     i;
  // Expected take order, and the write that retires each source
  reg  [4:0]  vx [0:6] = '{5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h14};
  reg  [31:0] ca [0:6] = '{A_REQ1, A_REQ2, A_REQ2, A_REQ2, 32'h0, A_REQ2, A_REQ2};
  reg  [7:0]  cv [0:6] = '{8'h7F, 8'hFE, 8'hFB, 8'hF7, 8'h00, 8'hBF, 8'h7F};

  assign {sleep_direct, adc_done, timer_high_ovf, timer_high_cmp,
          timer_low_ovf, timer_low_cmp, aec_ovf, timer_a_ovf} = pls;

  riex_ctrl u_riex_ctrl (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .ce                    (ce),
    .hsel                  (hsel),
    .haddr                 (haddr),
    .htrans                (htrans),
    .hwrite                (hwrite),
    .hsize                 (hsize),
    .hwdata                (hwdata),
    .hready                (hready),
    .hreadyout             (hreadyout),
    .hresp                 (hresp),
    .hrdata                (hrdata),
    .ext_int_pin           (ext_int_pin),
    .event_counter_int_pin (event_counter_int_pin),
    .wakeup_pins           (wakeup_pins),
    .timer_a_ovf           (timer_a_ovf),
    .aec_ovf               (aec_ovf),
    .timer_low_cmp         (timer_low_cmp),
    .timer_low_ovf         (timer_low_ovf),
    .timer_high_cmp        (timer_high_cmp),
    .timer_high_ovf        (timer_high_ovf),
    .serial_irq            (serial_irq),
    .adc_done              (adc_done),
    .sleep_direct          (sleep_direct),
    .instr_done            (instr_done),
    .cpu_hold              (cpu_hold),
    .exc_take              (exc_take),
    .exc_vector            (exc_vector),
    .exc_vec_addr          (exc_vec_addr),
    .int_mask              (int_mask)
  );
  riex_cpu_model u_riex_cpu_model (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .gap        (gap),
    .instr_done (instr_done)
  );

  always #5 hclk = ~hclk;

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (exc_take === 1'b1) takes <= takes + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end

  task print_verdict;
    begin
      $display("tests=%0d fails=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // One single word transfer; entered just after a rising edge
  task xfer(input w, input [31:0] a, input [7:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      v = hrdata[7:0];
    end
  endtask

  task wr(input [31:0] a, input [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input [31:0] a, input [7:0] e);
    begin
      xfer(1'b0, a, 8'h00);
      chk(v, e);
    end
  endtask

  task take(input [4:0] e);
    begin
      while (exc_take !== 1'b1) @(posedge hclk);
      chk({3'h0, exc_vector}, {3'h0, e});
    end
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    take(5'h00);
    chk(exc_vec_addr[7:0], 8'h00);
    chk({7'h0, int_mask}, 8'h01);
    rd(A_EDGE, 8'hE0);
    rd(A_REQ1, 8'h20);
    rd(32'h4, 8'h00);
    wr(A_EDGE, 8'hFF);
    rd(A_EDGE, 8'hE3);
    wr(A_EDGE, 8'h00);
    wr(A_EN1, 8'h07);
    ext_int_pin <= 2'h0;
    event_counter_int_pin <= 1'b0;
    repeat (4) @(posedge hclk);
    rd(A_REQ1, 8'h27);
    chk(takes[7:0], 8'h01);
    wr(A_MASK, 8'h00);
    take(5'h04);
    chk({7'h0, int_mask}, 8'h01);
    rd(A_REQ1, 8'h27);
    wr(A_REQ1, 8'hFE);
    rd(A_REQ1, 8'h26);
    wr(A_MASK, 8'h00);
    take(5'h05);
    wr(A_REQ1, 8'h00);
    wr(A_EDGE, 8'h03);
    ext_int_pin <= 2'h3;
    repeat (4) @(posedge hclk);
    rd(A_REQ1, 8'h23);
    wr(A_REQ1, 8'h00);
    ext_int_pin <= 2'h0;
    repeat (4) @(posedge hclk);
    rd(A_REQ1, 8'h20);
    // Slow core, all peripheral sources at once: strict priority order
    gap <= 4'h7;
    serial_irq <= 6'h21;
    pls <= 8'hFF;
    @(posedge hclk);
    pls <= 8'h00;
    wr(A_EN1, 8'h80);
    wr(A_EN2, 8'hCD);
    for (i = 0; i < 7; i = i + 1) begin
      wr(A_MASK, 8'h00);
      take(vx[i]);
      chk(exc_vec_addr[7:0], {2'h0, vx[i], 1'b0});
      if (ca[i] == 32'h0) serial_irq <= 6'h00;
      wr(ca[i], cv[i]);
    end
    repeat (20) @(posedge hclk);
    chk(takes[7:0], 8'h0A);
    // Frozen clock enable stretches the address phase
    ce <= 1'b0;
    fork
      wr(A_EN1, 8'h04);
      begin
        @(posedge hclk);
        chk({6'h0, hreadyout, hresp}, 8'h00);
        ce <= 1'b1;
      end
    join
    rd(A_EN1, 8'h04);
    // Wakeup pin, status word and the two other edge selects
    wr(A_EN1, 8'h20);
    wakeup_pins <= 8'hFE;
    repeat (2) @(posedge hclk);
    rd(A_WREQ, 8'h01);
    rd(A_STAT, 8'h89);
    wr(A_MASK, 8'h00);
    take(5'h09);
    chk(exc_vec_addr[7:0], 8'h12);
    wr(A_WREQ, 8'h00);
    rd(A_WREQ, 8'h00);
    wr(A_AUX, 8'h01);
    event_counter_int_pin <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(A_REQ1, 8'h24);
    wr(A_WEDG, 8'h01);
    wakeup_pins <= 8'hFF;
    repeat (2) @(posedge hclk);
    rd(A_WREQ, 8'h01);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    chk({7'h0, cpu_hold}, 8'h01);
    hresetn <= 1'b1;
    take(5'h00);
    rd(A_EN2, 8'h00);
    rd(A_MASK, 8'h01);
    rd(A_WREQ, 8'h00);
    print_verdict;
  end
endmodule // tb_top
